/* design/cbt_device.sv */
// command bus training control inside the memory die
`timescale 1ns/1ps
module bus_training_device
    import bus_training_pkg::*;
#(
    parameter int DQ_W = 16
)
(
    input  wire logic            clk_sys_in,
    input  wire logic            reset_n_in,
    input  wire logic            cke_in,
    input  wire logic            cs_in,
    input  wire logic [5:0]      ca_in,
    input  wire mrw_cmd_t        mrw_in,
    input  wire logic            dqs0_in,
    input  wire logic [DQ_W-1:0] dq_in,
    output logic [DQ_W-1:0]      dq_out,
    output logic [DQ_W-1:0]      dq_oe_out,
    output logic                 dqs1_out,
    output logic                 dqs1_oe_out,
    output logic                 mask1_out,
    output logic                 mask1_oe_out,
    output logic [DQ_W-1:0]      dq_term_en_out,
    output logic [2:0]           term_code_out,
    output logic                 operating_setpoint_out,
    output logic                 write_setpoint_out,
    output logic [6:0]           ca_reference_out,
    output logic                 training_active_out,
    output logic                 ready_out
);
    localparam logic [CNT_W-1:0] MRD_CNT   = CNT_W'(MODE_WRITE_DELAY_CYC);
    localparam logic [CNT_W-1:0] CAENT_CNT = CNT_W'(TRAINING_ENTRY_DELAY_CYC);
    localparam logic [CNT_W-1:0] MRW_CNT   = CNT_W'(MODE_WRITE_RECOVERY_CYC);

    ctl_state_t q;
    ctl_state_t d;
    logic       capture;
    logic [6:0] capture_value;
    logic [5:0] echo;
    logic       train_active;
    logic       accept_ref;
    logic       active_sp;

    function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
        count_down = (c == '0) ? '0 : c - CNT_W'(1);
    endfunction : count_down

    // ****************************************
    // mode writes and training sequence
    // ****************************************
    assign train_active = (q.st == ST_ENTRY) || (q.st == ST_TRAIN);
    assign accept_ref   = (q.st == ST_TRAIN);
    assign active_sp    = q.training_control_reg[TC_OPER_SP_BIT] ^ train_active;

    always_comb
    begin
        logic       wr_done;
        logic [7:0] wr_op;
        logic       wr_sp;
        wr_done = 1'b0;
        wr_op   = {q.pend_op_hi, mrw_in.op_lo};
        wr_sp   = q.training_control_reg[TC_WRITE_SP_BIT];
        d       = q;
        d.cnt   = count_down(q.cnt);

        // the entry and training states disable command decode, so writes only count outside training
        if (!train_active)
        begin
            if (mrw_in.first_valid)
            begin
                d.pend_addr  = mrw_in.addr;
                d.pend_op_hi = mrw_in.op_hi;
                d.pend_valid = 1'b1;
            end
            else if (mrw_in.second_valid && q.pend_valid)
            begin
                d.pend_valid = 1'b0;
                wr_done      = 1'b1;
                unique case (q.pend_addr)
                    MA_TRAINING_CONTROL: d.training_control_reg = wr_op;
                    MA_CA_REFERENCE:     d.ca_reference_reg[wr_sp] = wr_op[6:0];
                    MA_DATA_TERMINATION: d.data_termination_reg[wr_sp] = wr_op[TERM_FIELD_MSB:0];
                    default:             d.pend_valid = 1'b0;
                endcase
            end
        end

        // entry from idle or self refresh follows the same path
        unique case (q.st)
            ST_NORMAL:
            begin
                if (wr_done && d.training_control_reg[TC_TRAIN_ENABLE_BIT])
                begin
                    d.st  = ST_ARMED;
                    d.cnt = MRD_CNT;
                end
            end
            ST_ARMED:
            begin
                if (!q.training_control_reg[TC_TRAIN_ENABLE_BIT])
                    d.st = ST_NORMAL;
                else if (!cke_in && q.cnt == '0)
                begin
                    d.st        = ST_ENTRY;
                    d.cnt       = CAENT_CNT;
                    d.train_ref = q.ca_reference_reg[~q.training_control_reg[TC_OPER_SP_BIT]];
                end
                else if (wr_done)
                    d.cnt = MRD_CNT;
            end
            ST_ENTRY:
            begin
                if (cke_in)
                    d.st = ST_EXITED;
                else if (q.cnt == '0)
                    d.st = ST_TRAIN;
            end
            ST_TRAIN:
            begin
                if (cke_in)
                    d.st = ST_EXITED;
                else if (capture)
                    d.train_ref = capture_value;
            end
            ST_EXITED:
            begin
                // trained value dropped here, never copied into a set
                if (wr_done && !d.training_control_reg[TC_TRAIN_ENABLE_BIT])
                begin
                    d.st  = ST_RECOVER;
                    d.cnt = MRW_CNT;
                end
            end
            ST_RECOVER:
            begin
                if (q.cnt == '0)
                    d.st = ST_NORMAL;
            end
            default:
                d.st = ST_NORMAL;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            q                      <= '0;
            q.st                   <= ST_NORMAL;
            q.training_control_reg <= TRAINING_CONTROL_RST;
            q.ca_reference_reg     <= {2{CA_REFERENCE_RST}};
            q.data_termination_reg <= {2{DATA_TERMINATION_RST}};
        end
        else
        begin
            q <= d;
        end
    end

    // ****************************************
    // data line capture and echo
    // ****************************************
    // line 7 and mask line 0 are never looked at, so any level or float is fine
    strobe_capture u_capture (
        .clk_sys_in  (clk_sys_in),
        .reset_n_in  (reset_n_in),
        .enable_in   (accept_ref),
        .dqs_in      (dqs0_in),
        .dq_in       (dq_in[6:0]),
        .capture_out (capture),
        .value_out   (capture_value)
    );

    ca_echo u_echo (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .enable_in  (train_active),
        .cs_in      (cs_in),
        .ca_in      (ca_in),
        .echo_out   (echo)
    );

    // ****************************************
    // pin directions and termination
    // ****************************************
    always_comb
    begin
        dq_out    = '0;
        dq_oe_out = '0;
        if (train_active)
        begin
            dq_out[CA_ECHO_MSB:CA_ECHO_LSB]    = echo;
            dq_oe_out[CA_ECHO_MSB:CA_ECHO_LSB] = '1;
        end
    end

    // floated rather than driven: saves a driver and cannot fight a probe
    assign dqs1_out     = 1'b0;
    assign dqs1_oe_out  = 1'b0;
    assign mask1_out    = 1'b0;
    assign mask1_oe_out = 1'b0;

    assign term_code_out  = q.data_termination_reg[active_sp];
    assign dq_term_en_out = (term_code_out != '0) ? ~dq_oe_out : '0;

    assign operating_setpoint_out = active_sp;
    assign write_setpoint_out     = q.training_control_reg[TC_WRITE_SP_BIT];
    assign ca_reference_out       = train_active ? q.train_ref : q.ca_reference_reg[active_sp];
    assign training_active_out    = train_active;
    assign ready_out              = (q.st == ST_NORMAL) || (q.st == ST_ARMED);

    // ****************************************
    // checks
    // ****************************************
    AST_SP_SWAP_IN_TRAINING: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        training_active_out |-> (operating_setpoint_out != q.training_control_reg[TC_OPER_SP_BIT]))
        else $error("set point not swapped while training");

    AST_ENTRY_NEEDS_CKE_LOW: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        $rose(training_active_out) |-> ($past(q.st) == ST_ARMED && !$past(cke_in)))
        else $error("training entered without CKE low from armed");

    AST_EXIT_ON_CKE_HIGH: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (training_active_out && cke_in) |=> (!training_active_out
            && operating_setpoint_out == q.training_control_reg[TC_OPER_SP_BIT]))
        else $error("CKE high did not revert set point");

    // a short wait would find the sample one entry delay back still armed
    AST_ENTRY_DELAY: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        $rose(accept_ref) |-> $past(training_active_out, TRAINING_ENTRY_DELAY_CYC))
        else $error("reference accepted before entry delay");

    AST_ECHO_DRIVEN: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        training_active_out |-> (dq_oe_out == 16'h3f00 && dq_out[13:8] == echo))
        else $error("echo lines not driven while training");

    AST_REF_UPDATE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (q.st == ST_TRAIN && capture && !cke_in) |=> (ca_reference_out == $past(capture_value)))
        else $error("captured reference not applied");

    AST_NOT_RETAINED: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        $fell(training_active_out) |-> $stable(q.ca_reference_reg))
        else $error("trained reference stored into a set");

    AST_NO_DECODE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (training_active_out && $past(training_active_out)) |-> $stable(q.training_control_reg))
        else $error("mode write decoded during training");

    AST_RECOVERY: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (q.st == ST_EXITED ##1 q.st == ST_RECOVER) |-> !ready_out ##1 !ready_out ##1 (ready_out || q.st == ST_RECOVER))
        else $error("ready before mode write recovery");

    AST_TERM_INPUTS_ONLY: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (dq_term_en_out & dq_oe_out) == '0)
        else $error("termination on an output pin");

    AST_ENTRY_TAKES_ALTERNATE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        $rose(training_active_out)
            |-> (ca_reference_out == q.ca_reference_reg[~q.training_control_reg[TC_OPER_SP_BIT]]))
        else $error("entry did not load the alternate reference");

    AST_ENTRY_HOLDS_REF: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (q.st == ST_ENTRY && $past(q.st) == ST_ENTRY) |-> $stable(q.train_ref))
        else $error("reference changed during entry delay");

    AST_ARM_NEEDS_ENABLE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (q.st == ST_NORMAL ##1 q.st == ST_ARMED) |-> q.training_control_reg[TC_TRAIN_ENABLE_BIT])
        else $error("armed without training enable");

    AST_RECOVER_NEEDS_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (q.st == ST_EXITED ##1 q.st == ST_RECOVER) |-> !q.training_control_reg[TC_TRAIN_ENABLE_BIT])
        else $error("recovery started with training still enabled");

endmodule : bus_training_device

/* design/cbt_pkg.sv */
// shared constants, types and state layout for the command bus training block
package bus_training_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS             = 25000;
    localparam int MODE_WRITE_DELAY_NS       = 20;
    localparam int TRAINING_ENTRY_DELAY_NS   = 250;
    localparam int MODE_WRITE_RECOVERY_NS    = 20;
    // least times round up to whole cycles
    localparam int MODE_WRITE_DELAY_CYC      = (MODE_WRITE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TRAINING_ENTRY_DELAY_CYC  = (TRAINING_ENTRY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MODE_WRITE_RECOVERY_CYC   = (MODE_WRITE_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W                     = 8;

    // ****************************************
    // mode register addresses and fields
    // ****************************************
    localparam logic [5:0] MA_DATA_TERMINATION = 6'h0b;
    localparam logic [5:0] MA_CA_REFERENCE     = 6'h0c;
    localparam logic [5:0] MA_TRAINING_CONTROL = 6'h0d;
    localparam int         TC_TRAIN_ENABLE_BIT = 0;
    localparam int         TC_WRITE_SP_BIT     = 6;
    localparam int         TC_OPER_SP_BIT      = 7;
    localparam int         TERM_FIELD_MSB      = 2;
    localparam int         CA_ECHO_LSB         = 8;
    localparam int         CA_ECHO_MSB         = 13;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] TRAINING_CONTROL_RST = 8'h00;
    localparam logic [6:0] CA_REFERENCE_RST     = 7'h4d;
    localparam logic [2:0] DATA_TERMINATION_RST = 3'h0;

    typedef enum logic [2:0] {
        ST_NORMAL  = 3'b000,
        ST_ARMED   = 3'b001,
        ST_ENTRY   = 3'b010,
        ST_TRAIN   = 3'b011,
        ST_EXITED  = 3'b100,
        ST_RECOVER = 3'b101
    } train_state_t;

    // one decoded mode register write half pair
    typedef struct packed {
        logic       first_valid;
        logic       second_valid;
        logic [5:0] addr;
        logic       op_hi;
        logic [6:0] op_lo;
    } mrw_cmd_t;

    typedef struct packed {
        train_state_t          st;
        logic [7:0]            training_control_reg;
        logic [1:0][6:0]       ca_reference_reg;
        logic [1:0][2:0]       data_termination_reg;
        logic [5:0]            pend_addr;
        logic                  pend_op_hi;
        logic                  pend_valid;
        logic [CNT_W-1:0]      cnt;
        logic [6:0]            train_ref;
    } ctl_state_t;

    typedef struct packed {
        logic       dqs_prev;
        logic [6:0] value;
        logic       seen;
    } cap_state_t;

    typedef struct packed {
        logic [5:0] echo;
    } echo_state_t;

endpackage : bus_training_pkg

/* design/strobe_capture.sv */
// captures the reference value on every strobe toggle
`timescale 1ns/1ps
module strobe_capture
    import bus_training_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    input  wire logic       enable_in,
    input  wire logic       dqs_in,
    input  wire logic [6:0] dq_in,
    output logic            capture_out,
    output logic [6:0]      value_out
);
    cap_state_t q;
    cap_state_t d;

    always_comb
    begin
        d          = q;
        d.dqs_prev = dqs_in;
        d.seen     = 1'b0;
        // both strobe edges capture; later edges overwrite earlier ones
        if (enable_in && (dqs_in != q.dqs_prev))
        begin
            d.value = dq_in;
            d.seen  = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            q <= '0;
        else
            q <= d;
    end

    assign capture_out = q.seen;
    assign value_out   = q.value;

    AST_CAPTURE_ON_TOGGLE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (enable_in && dqs_in != $past(dqs_in)) |=> (capture_out && value_out == $past(dq_in)))
        else $error("strobe toggle did not capture data lines");

endmodule : strobe_capture

/* design/ca_echo.sv */
// latches the command bus on chip select and returns it on the data lines
`timescale 1ns/1ps
module ca_echo
    import bus_training_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       reset_n_in,
    input  wire logic       enable_in,
    input  wire logic       cs_in,
    input  wire logic [5:0] ca_in,
    output logic [5:0]      echo_out
);
    echo_state_t q;
    echo_state_t d;

    always_comb
    begin
        d = q;
        // no command decode here: the bus is just data while training
        if (enable_in && cs_in)
            d.echo = ca_in;
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            q <= '0;
        else
            q <= d;
    end

    assign echo_out = q.echo;

    AST_ECHO_FOLLOWS_CS: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
        (enable_in && cs_in) |=> (echo_out == $past(ca_in)))
        else $error("latched command bus not echoed");

endmodule : ca_echo

/* verification/ctrl_model.sv */
// controller-side model that drives the training pins of the memory die
`timescale 1ns/1ps
module ctrl_model
    import bus_training_pkg::*;
#(
    parameter int SETTLE_CYC = 10
)
(
    input  wire logic   clk_sys_in,
    output logic        cke_out,
    output logic        cs_out,
    output logic [5:0]  ca_out,
    output mrw_cmd_t    mrw_out,
    output logic        dqs0_out,
    output logic [15:0] dq_out
);
    // ****************************************
    // pin drivers
    // ****************************************
    initial
    begin
        cke_out  = 1'b1;
        cs_out   = 1'b0;
        ca_out   = 6'h00;
        mrw_out  = '0;
        dqs0_out = 1'b0;
        dq_out   = 16'h0000;
    end

    task automatic step();
        @(posedge clk_sys_in);
        #1;
    endtask : step

    task automatic mrw_write(input logic [5:0] addr, input logic [7:0] op);
        step();
        mrw_out = {2'b10, addr, op[7], 7'h00};
        step();
        mrw_out = {2'b01, 6'h00, 1'b0, op[6:0]};
        step();
        mrw_out = '0;
    endtask : mrw_write

    // one rank only, ck keeps one rate throughout
    task automatic cke_low();
        step();
        cke_out = 1'b0;
    endtask : cke_low

    task automatic cke_high();
        step();
        cke_out = 1'b1;
        repeat (SETTLE_CYC) step();
    endtask : cke_high

    task automatic set_ref(input logic [6:0] val);
        step();
        dq_out = {2'($urandom), 6'h00, 1'($urandom), val};
        repeat (4)
        begin
            step();
            dqs0_out = ~dqs0_out;
        end
        repeat (SETTLE_CYC) step();
    endtask : set_ref

    task automatic echo(input logic [5:0] val);
        step();
        cs_out = 1'b1;
        ca_out = val;
    endtask : echo

    task automatic deselect();
        step();
        cs_out = 1'b0;
        ca_out = ~ca_out;
    endtask : deselect
endmodule : ctrl_model

/* verification/command_bus_training_bench.sv */
// self-checking bench for the command bus training block
`timescale 1ns/1ps
module command_bus_training_bench
    import bus_training_pkg::*;
;
    typedef struct packed {
        logic        echo;
        logic [47:0] val;
    } note_t;

    logic        clk_sys = 1'b0;
    logic        reset_n;
    logic        cke, cs, dqs0, dqs1, dqs1_oe, mask1, mask1_oe;
    logic        osp_o, wsp_o, train_act, ready;
    logic [5:0]  ca, ca_v, prev;
    logic [6:0]  ref1, v, v_ref;
    logic [2:0]  term_code;
    logic [15:0] ctrl_dq, dq_in, dq_o, dq_oe, term_en;
    mrw_cmd_t    mrw;
    note_t       exp_q[$];
    note_t       item;
    int          errors = 0;
    int          comparisons = 0;
    logic        osp;

    always #12.5 clk_sys = ~clk_sys;

    // lines driven by the die win over the controller
    assign dq_in = (dq_oe & dq_o) | (~dq_oe & ctrl_dq);

    ctrl_model ctrl (.clk_sys_in(clk_sys), .cke_out(cke), .cs_out(cs), .ca_out(ca),
        .mrw_out(mrw), .dqs0_out(dqs0), .dq_out(ctrl_dq));

    bus_training_device #(.DQ_W(16)) dut (.clk_sys_in(clk_sys), .reset_n_in(reset_n), .cke_in(cke),
        .cs_in(cs), .ca_in(ca), .mrw_in(mrw), .dqs0_in(dqs0), .dq_in(dq_in), .dq_out(dq_o),
        .dq_oe_out(dq_oe), .dqs1_out(dqs1), .dqs1_oe_out(dqs1_oe), .mask1_out(mask1),
        .mask1_oe_out(mask1_oe), .dq_term_en_out(term_en), .term_code_out(term_code),
        .operating_setpoint_out(osp_o), .write_setpoint_out(wsp_o),
        .ca_reference_out(v_ref), .training_active_out(train_act), .ready_out(ready));

    // ****************************************
    // checking
    // ****************************************
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        if (errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    function automatic logic [47:0] exp_obs(input logic tr, input logic op, input logic wr,
            input logic rdy, input logic [2:0] tc, input logic [6:0] rf);
        logic [15:0] oe;
        oe = tr ? 16'h3f00 : 16'h0000;
        return {(tc != 3'h0) ? ~oe : 16'h0000, oe, 2'b00, tr, op, wr, rdy, tc, rf};
    endfunction : exp_obs

    always @(negedge clk_sys)
    begin
        if (exp_q.size() > 0)
        begin
            item = exp_q.pop_front();
            if (item.echo)
                check({32'h0, dq_o}, item.val);
            else
            begin
                check({term_en, dq_oe, dqs1_oe, mask1_oe, train_act, osp_o, wsp_o, ready,
                       term_code, v_ref}, item.val);
                check({30'h0, dqs1, mask1, dq_o & 16'hc0ff}, 48'h0);
            end
        end
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cyc

    task automatic expect_status(input logic [47:0] val);
        exp_q.push_back({1'b0, val});
        wait_cyc(1);
    endtask : expect_status

    // ****************************************
    // stimulus
    // ****************************************
    initial
    begin
        #(25 * 4000);
        errors++;
        stop_test();
    end

    initial
    begin
        reset_n = 1'b0;
        void'($urandom(81101));
        repeat (3) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        expect_status(exp_obs(0, 0, 0, 1, 3'h0, 7'h4d));
        ref1 = 7'($urandom);
        ctrl.mrw_write(MA_TRAINING_CONTROL, 8'h40);
        ctrl.mrw_write(MA_CA_REFERENCE, {1'b0, ref1});
        ctrl.mrw_write(MA_DATA_TERMINATION, 8'h03);
        wait_cyc(2);
        expect_status(exp_obs(0, 0, 1, 1, 3'h0, 7'h4d));
        // second round starts from set point one
        for (int r = 0; r < 2; r++)
        begin
            osp = r[0];
            ctrl.mrw_write(MA_TRAINING_CONTROL, {osp, 7'h41});
            wait_cyc(2 + MODE_WRITE_DELAY_CYC);
            ctrl.cke_low();
            wait_cyc(2);
            expect_status(exp_obs(1, ~osp, 1, 0, osp ? 3'h0 : 3'h3, osp ? 7'h4d : ref1));
            ctrl.mrw_write(MA_TRAINING_CONTROL, 8'h00);
            wait_cyc(TRAINING_ENTRY_DELAY_CYC);
            for (int i = 0; i < 3; i++)
            begin
                v = (i == 0) ? 7'h7f : 7'($urandom);
                ctrl.set_ref(v);
                expect_status(exp_obs(1, ~osp, 1, 0, osp ? 3'h0 : 3'h3, v));
            end
            for (int i = 0; i < 4; i++)
            begin
                ca_v = (i == 0) ? 6'h2a : 6'($urandom);
                ctrl.echo(ca_v);
                if (i > 0)
                    exp_q.push_back({1'b1, 32'h0, 2'b00, prev, 8'h00});
                prev = ca_v;
            end
            ctrl.deselect();
            exp_q.push_back({1'b1, 32'h0, 2'b00, prev, 8'h00});
            wait_cyc(1);
            ctrl.cke_high();
            expect_status(exp_obs(0, osp, 1, 0, osp ? 3'h3 : 3'h0, osp ? ref1 : 7'h4d));
            ctrl.mrw_write(MA_TRAINING_CONTROL, {osp, 7'h40});
            wait_cyc(2 + MODE_WRITE_RECOVERY_CYC);
            expect_status(exp_obs(0, osp, 1, 1, osp ? 3'h3 : 3'h0, osp ? ref1 : 7'h4d));
            ctrl.mrw_write(MA_TRAINING_CONTROL, 8'hc0);
            wait_cyc(2);
            expect_status(exp_obs(0, 1, 1, 1, 3'h3, ref1));
        end
        wait_cyc(2);
        stop_test();
    end
endmodule : command_bus_training_bench
